// ===== rtl/sleep_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the sleep controller
// Summary of operation
// - Power-down is entered only by executing the sleep instruction.
// - Entering power-down clears the watchdog; it runs on if enabled in sleep.
// - Completed entry clears powerdown_flag and sets timeout_flag.
// - The core clock is stopped while powered down.
// - The 31 kHz low-frequency oscillator keeps running in power-down.
// - The secondary timer oscillator keeps running in power-down.
// - The converter runs in power-down only with its dedicated oscillator selected.
// - General-purpose pins hold their drive state while powered down.
// - Power-down changes no reset source except the watchdog.
// - Wake sources: pin, brownout, power-on, watchdog, enabled interrupts.
// - Pin, brownout, power-on wake resets; watchdog or interrupt wake resumes.
// - The instruction after sleep is prefetched during sleep execution.
// - Interrupt wakes only if its own enable is set; global enable ignored.
// - Wake with global enable clear continues after the sleep instruction.
// - Wake with global enable set runs next instruction, then vectors.
// - The interrupt routine after wake starts at address 0004h.
// - Interrupt or watchdog wake-up clears the watchdog count.
// - Pending enabled interrupt, global enable clear: sleep is a no-op.
// - Interrupt during or after sleep: finish entry, then wake at once.
// - Crystal modes delay restart after wake by 1024 oscillator periods.
// - Watchdog timeout while asleep wakes without reset and updates flags.
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH

`define INTCTL_OFS     8'h00
`define STATUS_OFS     8'h04
`define WDOG_CTL_OFS   8'h08
`define SLPSTATE_OFS   8'h0c

`define GLOBAL_EN_BIT  7
`define TMO_FLAG_BIT   4
`define PDN_FLAG_BIT   3
`define SOFT_EN_BIT    0
`define PERIOD_SEL_MSB 5
`define PERIOD_SEL_LSB 1

`define INTCTL_RST     8'h00
`define STATUS_LO_RST  3'h0
`define WDOG_CTL_RST   6'h16

`define ISR_VECTOR     16'h0004
`define OST_PERIODS    1024
`define OSC_PER_HCLK   1
`define OST_CYCLES     (`OST_PERIODS * `OSC_PER_HCLK)
`define FLUSH_NOPS     2
`define WDOG_BASE_EXP  5
`define PERIOD_SEL_MAX 5'h12

`endif

// ===== rtl/sleep_ctrl_pkg.sv
// Types shared by the sleep controller and its watchdog
package sleep_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_ENTRY  = 3'b001,
        ST_ASLEEP = 3'b010,
        ST_OST    = 3'b011,
        ST_RESUME = 3'b100,
        ST_FLUSH  = 3'b101
    } sleep_state_type;

    typedef struct packed {
        logic pin_req;
        logic pin_en;
        logic brown_req;
        logic brown_en;
        logic por_req;
    } reset_src_type;

    typedef struct packed {
        logic [1:0] wdog_mode;
        logic       xtal_osc;
        logic       adc_own_osc;
    } config_type;

endpackage : sleep_ctrl_pkg

// ===== rtl/watchdog_counter.sv
// Watchdog count on the low-frequency tick with selectable period
`timescale 1ns/10ps
`include "sleep_ctrl_map.svh"
module watchdog_counter
    import sleep_ctrl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        tick,
    input  wire logic        clear,
    input  wire logic        run,
    input  wire logic [4:0]  period,
    output logic             timeout,
    output logic [23:0]      count
);

    // Last count of the period; select codes past the top saturate
    function automatic logic [23:0] last_count(input logic [4:0] sel);
        logic [4:0] s;
        s = (sel > `PERIOD_SEL_MAX) ? `PERIOD_SEL_MAX : sel;
        last_count = (24'h1 << (s + 5'(`WDOG_BASE_EXP))) - 24'h1;
    endfunction : last_count

    // Count ticks; a clear always wins so a stale timeout cannot fire
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count   <= 24'h0;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (clear || !run) begin
                count <= 24'h0;
            end else if (tick) begin
                if (count >= last_count(period)) begin
                    count   <= 24'h0;
                    timeout <= 1'b1;
                end else begin
                    count <= count + 24'h1;
                end
            end
        end
    end

endmodule : watchdog_counter

// ===== rtl/sleep_mode_controller.sv
// Sleep (power-down) controller with AHB-Lite register access
`timescale 1ns/10ps
`include "sleep_ctrl_map.svh"
module sleep_mode_controller
    import sleep_ctrl_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          sleep_exec,
    input  wire logic          clrwdt_exec,
    input  wire logic [6:0]    irq_flags,
    input  wire logic          lf_tick,
    input  wire reset_src_type rst_src,
    input  wire config_type    cfg,
    input  wire logic          t1osc_req,
    input  wire logic          adc_req,
    output logic               cpu_clk_en,
    output logic               prefetch_req,
    output logic               forced_nop,
    output logic               vector_fetch,
    output logic [15:0]        isr_addr,
    output logic               io_hold,
    output logic               sleeping,
    output logic               lfosc_run,
    output logic               t1osc_run,
    output logic               adc_run,
    output logic               device_reset
);

    sleep_state_type state_r;
    sleep_state_type state_nxt;
    logic [7:0]      intctl_r;
    logic [2:0]      status_lo_r;
    logic [5:0]      wdog_ctl_r;
    logic            timeout_flag_r;
    logic            powerdown_flag_r;
    logic [9:0]      ost_cnt_r;
    logic            flush_cnt_r;
    logic            wr_pend_r;
    logic            rd_pend_r;
    logic [7:0]      addr_r;
    logic            ap_ok;
    logic            glob_en;
    logic            irq_wake;
    logic            reset_wake;
    logic            wdog_tmo;
    logic            wdog_run;
    logic            wdog_clear;
    logic            in_sleep;
    logic            sleep_nxt;
    logic            wake;
    logic [23:0]     wdog_count;

    // Bus read mux; unmapped offsets read as zero
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            `INTCTL_OFS:   rd_word = {24'h0, intctl_r};
            `STATUS_OFS:   rd_word = {27'h0, timeout_flag_r, powerdown_flag_r, status_lo_r};
            `WDOG_CTL_OFS: rd_word = {26'h0, wdog_ctl_r};
            `SLPSTATE_OFS: rd_word = {28'h0, sleeping, state_r};
            default:       rd_word = 32'h0;
        endcase
    endfunction : rd_word

    // Decode of wake and enable conditions
    assign glob_en    = intctl_r[`GLOBAL_EN_BIT];
    assign irq_wake   = |(irq_flags & intctl_r[6:0]);
    assign reset_wake = (rst_src.pin_req & rst_src.pin_en)
                      | (rst_src.brown_req & rst_src.brown_en)
                      | rst_src.por_req;
    assign in_sleep   = (state_r == ST_ENTRY) || (state_r == ST_ASLEEP);
    assign wake       = (state_r == ST_ASLEEP) && (irq_wake || wdog_tmo);
    assign sleep_nxt  = (state_nxt == ST_ENTRY) || (state_nxt == ST_ASLEEP)
                      || (state_nxt == ST_OST);
    assign ap_ok      = hsel && hready && htrans[1];

    // Watchdog enable per configuration mode; mode 10 stops it in sleep
    assign wdog_run = (cfg.wdog_mode == 2'b11)
                    || ((cfg.wdog_mode == 2'b01) && wdog_ctl_r[`SOFT_EN_BIT])
                    || ((cfg.wdog_mode == 2'b10) && !in_sleep);

    // Watchdog held clear on clear command, entry, wake and the start-up delay
    assign wdog_clear = (clrwdt_exec && state_r == ST_RUN)
                      || (state_r == ST_ENTRY)
                      || wake
                      || (state_r == ST_OST);

    watchdog_counter u_wdog (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (lf_tick),
        .clear   (wdog_clear),
        .run     (wdog_run),
        .period  (wdog_ctl_r[`PERIOD_SEL_MSB:`PERIOD_SEL_LSB]),
        .timeout (wdog_tmo),
        .count   (wdog_count)
    );

    // Sleep sequence: entry, sleep, start-up delay, resume, vector flush
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                // A pending enabled interrupt with global enable clear voids sleep
                if (sleep_exec && !(irq_wake && !glob_en)) begin
                    state_nxt = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                state_nxt = ST_ASLEEP;
            end
            ST_ASLEEP: begin
                if (wake) begin
                    state_nxt = cfg.xtal_osc ? ST_OST : ST_RESUME;
                end
            end
            ST_OST: begin
                if (ost_cnt_r == 10'h0) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_nxt = glob_en ? ST_FLUSH : ST_RUN;
            end
            ST_FLUSH: begin
                if (!flush_cnt_r) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        // Reset-type wake sources restart the device from any state
        if (reset_wake) begin
            state_nxt = ST_RUN;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start-up delay and forced no-op counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ost_cnt_r   <= 10'h0;
            flush_cnt_r <= 1'b0;
        end else begin
            if (state_r != ST_OST && state_nxt == ST_OST) begin
                ost_cnt_r <= 10'(`OST_CYCLES - 1);
            end else if (state_r == ST_OST && ost_cnt_r != 10'h0) begin
                ost_cnt_r <= ost_cnt_r - 10'h1;
            end
            if (state_nxt == ST_FLUSH && state_r != ST_FLUSH) begin
                flush_cnt_r <= 1'(`FLUSH_NOPS - 1);
            end else if (state_r == ST_FLUSH) begin
                flush_cnt_r <= 1'b0;
            end
        end
    end

    // Timeout and powerdown flags; a watchdog timeout is recorded last so it wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timeout_flag_r   <= 1'b1;
            powerdown_flag_r <= 1'b1;
        end else begin
            if (state_r == ST_ENTRY) begin
                timeout_flag_r   <= 1'b1;
                powerdown_flag_r <= 1'b0;
            end else if (clrwdt_exec && state_r == ST_RUN) begin
                timeout_flag_r   <= 1'b1;
                powerdown_flag_r <= 1'b1;
            end
            if (wdog_tmo) begin
                timeout_flag_r <= 1'b0;
            end
        end
    end

    // Core-facing controls follow the next state so they line up with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clk_en   <= 1'b1;
            prefetch_req <= 1'b0;
            forced_nop   <= 1'b0;
            vector_fetch <= 1'b0;
            isr_addr     <= `ISR_VECTOR;
        end else begin
            cpu_clk_en   <= (state_nxt == ST_RUN) || (state_nxt == ST_RESUME)
                         || (state_nxt == ST_FLUSH);
            prefetch_req <= (state_nxt == ST_ENTRY);
            forced_nop   <= (state_nxt == ST_FLUSH);
            vector_fetch <= (state_r == ST_FLUSH) && (state_nxt == ST_RUN)
                         && !reset_wake;
            isr_addr     <= `ISR_VECTOR;
        end
    end

    // Pin hold, oscillators, converter clock and reset request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_hold      <= 1'b0;
            sleeping     <= 1'b0;
            lfosc_run    <= 1'b0;
            t1osc_run    <= 1'b0;
            adc_run      <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            io_hold      <= sleep_nxt;
            sleeping     <= sleep_nxt;
            lfosc_run    <= 1'b1;
            t1osc_run    <= t1osc_req;
            adc_run      <= adc_req && (!sleep_nxt || cfg.adc_own_osc);
            // Only the watchdog reset is swapped for a wake while asleep
            device_reset <= reset_wake
                         || (wdog_tmo && state_r != ST_ASLEEP);
        end
    end

    // AHB-Lite slave: writes take no wait, reads take one so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= ap_ok && hwrite && (hsize == 3'b010);
            rd_pend_r <= ap_ok && !hwrite;
            if (ap_ok) begin
                addr_r <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
            end
            hreadyout <= !(ap_ok && !hwrite);
            hresp     <= 1'b0;
            if (rd_pend_r) begin
                hrdata <= rd_word(addr_r);
            end
        end
    end

    // Software-writable registers; flag bits of the status word ignore writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intctl_r    <= `INTCTL_RST;
            status_lo_r <= `STATUS_LO_RST;
            wdog_ctl_r  <= `WDOG_CTL_RST;
        end else if (wr_pend_r) begin
            case (addr_r)
                `INTCTL_OFS:   intctl_r    <= hwdata[7:0];
                `STATUS_OFS:   status_lo_r <= hwdata[2:0];
                `WDOG_CTL_OFS: wdog_ctl_r  <= hwdata[5:0];
                default:       intctl_r    <= intctl_r;
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_entry_only_sleep: assert property (
        (state_r == ST_RUN && !sleep_exec) |=> state_r != ST_ENTRY)
        else $error("sleep entered without the sleep instruction");

    chk_entry_clears_wdog: assert property (
        state_r == ST_ENTRY |=> wdog_count == 24'h0)
        else $error("watchdog not cleared on sleep entry");

    chk_entry_flags: assert property (
        (state_r == ST_ENTRY && !wdog_tmo) |=> timeout_flag_r && !powerdown_flag_r)
        else $error("flags not updated on sleep entry");

    chk_core_clock_off: assert property (
        (state_r == ST_ASLEEP || state_r == ST_OST) |-> !cpu_clk_en && io_hold)
        else $error("core clock running or pins released while asleep");

    chk_adc_in_sleep: assert property (
        (state_r == ST_ASLEEP && !cfg.adc_own_osc) |-> !adc_run)
        else $error("converter running in sleep without its own oscillator");

    chk_reset_wake: assert property (
        reset_wake |=> device_reset && state_r == ST_RUN)
        else $error("reset wake source did not reset");

    chk_prefetch_entry: assert property (
        ($rose(state_r == ST_ENTRY) && !reset_wake)
        |-> prefetch_req ##1 state_r == ST_ASLEEP)
        else $error("no prefetch while sleep executes");

    chk_irq_wake: assert property (
        (state_r == ST_ASLEEP && irq_wake && !reset_wake && !cfg.xtal_osc)
        |=> state_r == ST_RESUME)
        else $error("enabled interrupt did not wake");

    chk_resume_inline: assert property (
        (state_r == ST_RESUME && !glob_en && !reset_wake)
        |=> state_r == ST_RUN && !forced_nop)
        else $error("wake with global enable clear did not continue in line");

    chk_vector_flush: assert property (
        (state_r == ST_RESUME && glob_en && !reset_wake)
        |=> forced_nop [*2] ##1 (vector_fetch && isr_addr == 16'h0004))
        else $error("vector not fetched after two forced no-ops");

    chk_wake_clears_wdog: assert property (
        (wake && !reset_wake) |=> wdog_count == 24'h0)
        else $error("watchdog not cleared on wake");

    chk_sleep_as_nop: assert property (
        (state_r == ST_RUN && sleep_exec && irq_wake && !glob_en)
        |=> state_r == ST_RUN && $stable(powerdown_flag_r))
        else $error("sleep not treated as no-op with pending interrupt");

    chk_ost_hold: assert property (
        (state_r == ST_OST && ost_cnt_r != 10'h0 && !reset_wake)
        |=> state_r == ST_OST && wdog_count == 24'h0)
        else $error("start-up delay cut short");

    chk_wdog_sleep_wake: assert property (
        (state_r == ST_ASLEEP && wdog_tmo) |=> !device_reset && !timeout_flag_r)
        else $error("watchdog in sleep reset instead of waking");

    cov_irq_wake_vector: cover property (
        state_r == ST_RESUME && glob_en ##3 vector_fetch);

    cov_sleep_nop: cover property (
        state_r == ST_RUN && sleep_exec && irq_wake && !glob_en);

    cov_wdog_wake: cover property (
        state_r == ST_ASLEEP && wdog_tmo);

    cov_ost_done: cover property (
        state_r == ST_OST ##1 state_r == ST_RESUME);

endmodule : sleep_mode_controller

// ===== verif/irq_reset_source.sv
// Interrupt, reset and low-frequency tick sources facing the sleep controller
`timescale 1ns/10ps
module irq_reset_source
    import sleep_ctrl_pkg::*;
(
    input  wire logic     hclk,
    input  wire logic     hresetn,
    input  wire logic [6:0] irq_set,
    input  wire logic     irq_clr,
    input  wire logic     pin_cmd,
    output logic [6:0]    irq_flags,
    output logic          lf_tick,
    output reset_src_type rst_src
);
    logic [1:0] div_r;

    // Flags latch whatever their enable, as real peripherals do
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) irq_flags <= 7'h00;
        else if (irq_clr) irq_flags <= 7'h00;
        else irq_flags <= irq_flags | irq_set;
    end

    // Tick every four clocks; runs free so the watchdog keeps time asleep
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) div_r <= 2'h0;
        else div_r <= div_r + 2'h1;
    end
    assign lf_tick = (div_r == 2'h3);

    // Pin and brownout enabled; brownout and power-on stay quiet
    always_comb begin
        rst_src = '0;
        rst_src.pin_req = pin_cmd;
        rst_src.pin_en = 1'h1;
        rst_src.brown_en = 1'h1;
    end
endmodule : irq_reset_source

// ===== verif/testbench.sv
// Self-checking bench for the sleep controller
`timescale 1ns/10ps
module testbench;
    import sleep_ctrl_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_exec;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] irq_flags, irq_set;
    logic lf_tick, t1osc_req, adc_req, cpu_clk_en, prefetch_req, forced_nop;
    logic vector_fetch, io_hold, sleeping, lfosc_run, t1osc_run, adc_run;
    logic device_reset, irq_clr, pin_cmd;
    logic [15:0] isr_addr;
    reset_src_type rst_src;
    config_type cfg;
    int errors, checks, n;

    sleep_mode_controller sleep_mode_controller_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sleep_exec(sleep_exec), .clrwdt_exec(1'h0),
        .irq_flags(irq_flags), .lf_tick(lf_tick), .rst_src(rst_src), .cfg(cfg),
        .t1osc_req(t1osc_req), .adc_req(adc_req), .cpu_clk_en(cpu_clk_en),
        .prefetch_req(prefetch_req), .forced_nop(forced_nop),
        .vector_fetch(vector_fetch), .isr_addr(isr_addr), .io_hold(io_hold),
        .sleeping(sleeping), .lfosc_run(lfosc_run), .t1osc_run(t1osc_run),
        .adc_run(adc_run), .device_reset(device_reset));
    irq_reset_source irq_reset_source_i (.hclk(hclk), .hresetn(hresetn),
        .irq_set(irq_set), .irq_clr(irq_clr), .pin_cmd(pin_cmd),
        .irq_flags(irq_flags), .lf_tick(lf_tick), .rst_src(rst_src));

    // 10 MHz clock
    always #50 hclk = ~hclk;

    task results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            errors++;
        end
    endtask : chk

    // Bounded wait for the slave's ready, sampled at the rising edge
    task rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
            if (k > 20) begin
                chk("hready wait", 1, 0);
                results();
            end
        end while (hreadyout !== 1'h1);
    endtask : rdy

    task bw(input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1; haddr <= a; hwrite <= 1'h1; htrans <= 2'h2;
        rdy();
        htrans <= 2'h0; hwdata <= d;
        rdy();
    endtask : bw

    // Read one word and compare; read data is taken at the closing edge
    task rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        @(posedge hclk);
        hsel <= 1'h1; haddr <= a; hwrite <= 1'h0; htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        rdy();
        chk(name, exp, hrdata);
        chk("hresp", 0, hresp);
    endtask : rd

    task go(input int c);
        repeat (c) @(posedge hclk);
    endtask : go

    task pulse_irq(input logic [6:0] v);
        @(posedge hclk); irq_set <= v;
        @(posedge hclk); irq_set <= 7'h00;
    endtask : pulse_irq

    task clr_irq;
        @(posedge hclk); irq_clr <= 1'h1;
        @(posedge hclk); irq_clr <= 1'h0;
    endtask : clr_irq

    // Sleep entry; checks the entry cycle and first asleep cycle
    task nap;
        @(posedge hclk); sleep_exec <= 1'h1;
        @(posedge hclk); sleep_exec <= 1'h0;
        #1;
        chk("prefetch_req", 1, prefetch_req);
        chk("cpu_clk_en", 0, cpu_clk_en);
        @(posedge hclk); #1;
        chk("io_hold", 1, io_hold);
    endtask : nap

    // Wait for the core clock to come back, counting cycles
    task wake(input int lim);
        n = 0;
        while (cpu_clk_en !== 1'h1) begin
            @(posedge hclk); #1; n++;
            if (n > lim) begin
                chk("wake wait", 1, 0);
                results();
            end
        end
    endtask : wake

    task t_regs;
        rd("interrupt_control", 32'h00, 32'h00);
        rd("watchdog_control", 32'h08, 32'h16);
        bw(32'h04, 32'hff);
        rd("processor_status", 32'h04, 32'h1f);
        bw(32'h04, 32'h00);
        rd("processor_status", 32'h04, 32'h18);
        bw(32'h10, 32'hff);
        rd("unmapped", 32'h10, 32'h00);
    endtask : t_regs

    // Pending enabled flag with global enable clear: sleep does nothing
    task t_noop;
        bw(32'h00, 32'h01);
        pulse_irq(7'h01);
        @(posedge hclk); sleep_exec <= 1'h1;
        @(posedge hclk); sleep_exec <= 1'h0;
        #1;
        chk("sleeping", 0, sleeping);
        rd("processor_status", 32'h04, 32'h18);
        clr_irq();
    endtask : t_noop

    // Interrupt wake with global enable clear continues in line
    task t_irq_inline;
        cfg.adc_own_osc <= 1'h0;
        nap();
        pulse_irq(7'h02);
        go(4); #1;
        chk("cpu_clk_en", 0, cpu_clk_en);
        chk("adc_run", 0, adc_run);
        chk("lfosc_run", 1, lfosc_run);
        chk("t1osc_run", 1, t1osc_run);
        rd("processor_status", 32'h04, 32'h10);
        pulse_irq(7'h01);
        wake(8);
        repeat (4) begin
            @(posedge hclk); #1;
            chk("forced_nop", 0, forced_nop | vector_fetch);
        end
        clr_irq();
    endtask : t_irq_inline

    // Interrupt wake with global enable set vectors after two forced no-ops
    task t_irq_vector;
        cfg.adc_own_osc <= 1'h1;
        bw(32'h00, 32'h81);
        nap();
        go(1); #1;
        chk("adc_run", 1, adc_run);
        pulse_irq(7'h01);
        wake(8);
        chk("forced_nop", 0, forced_nop);
        @(posedge hclk); #1;
        chk("forced_nop", 1, forced_nop);
        @(posedge hclk); #1;
        chk("forced_nop", 1, forced_nop);
        @(posedge hclk); #1;
        chk("vector_fetch", 1, vector_fetch);
        chk("isr_addr", 32'h0004, isr_addr);
        clr_irq();
    endtask : t_irq_vector

    // Interrupt during entry with crystal start-up delay
    task t_xtal;
        cfg.xtal_osc <= 1'h1;
        bw(32'h00, 32'h01);
        @(posedge hclk); sleep_exec <= 1'h1; irq_set <= 7'h01;
        @(posedge hclk); sleep_exec <= 1'h0; irq_set <= 7'h00;
        // Step off the edge so the clock enable is seen after it has dropped
        #1;
        wake(1100);
        // Entry, one asleep cycle and 1024 start-up cycles before the clock returns
        chk("start-up delay", 1026, n);
        rd("processor_status", 32'h04, 32'h10);
        cfg.xtal_osc <= 1'h0;
        clr_irq();
    endtask : t_xtal

    task t_wdog_wake;
        cfg.wdog_mode <= 2'h3;
        bw(32'h08, 32'h00);
        bw(32'h00, 32'h00);
        nap();
        wake(400);
        cfg.wdog_mode <= 2'h0;
        chk("device_reset", 0, device_reset);
        rd("processor_status", 32'h04, 32'h00);
        bw(32'h08, 32'h16);
    endtask : t_wdog_wake

    // Watchdog mode that stops in sleep must not wake the core
    task t_wdog_off;
        cfg.wdog_mode <= 2'h2;
        bw(32'h08, 32'h00);
        nap();
        go(200); #1;
        chk("cpu_clk_en", 0, cpu_clk_en);
        bw(32'h00, 32'h01);
        pulse_irq(7'h01);
        wake(8);
        cfg.wdog_mode <= 2'h0;
        clr_irq();
        bw(32'h08, 32'h16);
    endtask : t_wdog_off

    task t_pin;
        nap();
        @(posedge hclk); pin_cmd <= 1'h1;
        go(2); #1;
        chk("device_reset", 1, device_reset);
        chk("cpu_clk_en", 1, cpu_clk_en);
        @(posedge hclk); pin_cmd <= 1'h0;
        go(3);
    endtask : t_pin

    // Everything starts defined, reset held three cycles
    initial begin
        hclk = 1'h0; hresetn = 1'h0; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'h0; hsize = 3'h2; hwdata = 32'h0; sleep_exec = 1'h0;
        irq_set = 7'h00; irq_clr = 1'h0; pin_cmd = 1'h0; t1osc_req = 1'h1;
        adc_req = 1'h1; cfg = '0; errors = 0; checks = 0;
        go(3);
        hresetn <= 1'h1;
        t_regs();
        t_noop();
        t_irq_inline();
        t_irq_vector();
        t_xtal();
        t_wdog_wake();
        t_wdog_off();
        t_pin();
        results();
    end
endmodule : testbench
